/* pkg/dpll_loop_regs.vh */
// What this block does
// [R1] divider changes up to 100 ppm are taken while the loop stays closed; code goes brief on any integer or denominator change
// [R2] shadow divider values take effect only when 0x01 is written to 0x000F
// [R3] a numerator-only commit applies at once, with no holdover
// [R4] an integer or denominator commit in closed loop causes a brief holdover, then resumes
// [R5] each detector level saturates between -2048 and +2048
// [R6] below -1024 reports unlock, above +1024 lock, otherwise holds
// [R7] fill and drain amounts are programmable 8-bit values
// [R8] per sample: fill if magnitude within threshold, else drain
// [R9] phase threshold is 24 bits, compared with phase error magnitude
// [R10] entering free run or holdover forces phase unlock
// [R11] switch, phase step or bandwidth change freezes the detectors
// [R12] frequency detector uses the same scheme on period deviation
// [R13] the tuning word is clamped to a programmed window
// [R14] tuning words are averaged over a set interval, driven in holdover
// [R15] switchover: brief holdover, load parameters, resume, keep lock state
// [R16] holdover holds frequency; entered with no reference or on request
// [R17] a valid reference ends holdover, then parameters reload and loop closes
// [R18] forced holdover bit keeps holdover until software clears it
// [R19] ratio is integer+1+num/den; zero num or den bypasses the fraction
// [R20] detectors reset to empty level and unlocked
`ifndef DPLL_LOOP_REGS_VH
`define DPLL_LOOP_REGS_VH
// register indices, byte address is four times the index
`define IDX_UPDATE   12'h00F
`define IDX_FB_INT   12'h444
`define IDX_FB_NUM   12'h447
`define IDX_FB_DEN   12'h44A
`define IDX_CTRL     12'h500
`define IDX_PH_THR   12'h501
`define IDX_FR_THR   12'h502
`define IDX_RATES    12'h503
`define IDX_CLAMP_LO 12'h504
`define IDX_CLAMP_HI 12'h505
`define IDX_AVG      12'h506
`define IDX_STATUS   12'h507
`define IDX_AVG_FTW  12'h508
// commit value and control bits
`define COMMIT_VAL   8'h01
`define CTRL_HOLD    0
`define CTRL_FREE    1
// detector levels in 13-bit two's complement
`define LVL_FULL     13'h0800
`define LVL_EMPTY    13'h1800
`define LVL_HIGH     13'h0400
`define LVL_LOW      13'h1C00
// reset values
`define CLAMP_HI_RST 32'hFFFFFFFF
`define AVG_SH_RST   4'h4
// sequence timer loads in clock cycles, each sequence lasts one cycle longer
`define BRIEF_CYC    8'h10
`define RECOV_CYC    8'h08
`endif

/* rtl/dpll_loop_control.v */
`include "dpll_loop_regs.vh"

module dpll_loop_control #(
  parameter ERR_W = 24,
  parameter FTW_W = 32
) (
  // clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // ahb-lite slave
  input  wire             hsel,
  input  wire [31:0]      haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output reg              hreadyout,
  output reg  [31:0]      hrdata,
  output reg              hresp,
  // detector samples
  input  wire             pd_valid,
  input  wire [ERR_W-1:0] phase_err,
  input  wire [ERR_W-1:0] period_dev,
  // loop events
  input  wire             ref_valid,
  input  wire             ref_switch,
  input  wire             phase_step,
  input  wire             bw_change,
  // loop filter tuning word
  input  wire             ftw_valid,
  input  wire [FTW_W-1:0] ftw_in,
  // loop outputs
  output reg              phase_lock,
  output reg              freq_lock,
  output reg  [2:0]       loop_state,
  output reg              param_load,
  output reg  [FTW_W-1:0] ftw_out,
  output reg  [17:0]      fb_integer,
  output reg  [23:0]      fb_numerator,
  output reg  [23:0]      fb_denominator,
  output reg              frac_enable
);

  localparam ST_FREE    = 3'd0;
  localparam ST_HOLD    = 3'd1;
  localparam ST_BRIEF   = 3'd2;
  localparam ST_RECOVER = 3'd3;
  localparam ST_CLOSED  = 3'd4;

  // magnitude of a two's complement sample
  function [ERR_W-1:0] mag;
    input [ERR_W-1:0] v;
    begin
      mag = v[ERR_W-1] ? (~v + 1'b1) : v;
    end
  endfunction

  // one fill or drain step with saturation
  function [12:0] bucket;
    input [12:0] lvl;
    input        pass;
    input [7:0]  fill;
    input [7:0]  drain;
    reg   [13:0] t;
    begin
      if (pass)
        t = {lvl[12], lvl} + {6'h00, fill};
      else
        t = {lvl[12], lvl} - {6'h00, drain};
      if ($signed(t) > $signed({1'b0, `LVL_FULL}))
        bucket = `LVL_FULL;
      else if ($signed(t) < $signed({1'b1, `LVL_EMPTY}))
        bucket = `LVL_EMPTY;
      else
        bucket = t[12:0];
    end
  endfunction

  // hysteresis on the level
  function lock_next;
    input [12:0] lvl;
    input        cur;
    begin
      if ($signed(lvl) < $signed(`LVL_LOW))
        lock_next = 1'b0;
      else if ($signed(lvl) > $signed(`LVL_HIGH))
        lock_next = 1'b1;
      else
        lock_next = cur;
    end
  endfunction

  // clamp a tuning word into the window
  function [FTW_W-1:0] clamp;
    input [FTW_W-1:0] w;
    input [FTW_W-1:0] lo;
    input [FTW_W-1:0] hi;
    begin
      if (w < lo)
        clamp = lo;
      else if (w > hi)
        clamp = hi;
      else
        clamp = w;
    end
  endfunction

  reg  [2:0]        state_r;
  reg  [7:0]        tmr_r;
  reg               wr_pend_r;
  reg  [11:0]       widx_r;
  reg  [7:0]        update_r;
  reg  [17:0]       sh_int_r;
  reg  [23:0]       sh_num_r;
  reg  [23:0]       sh_den_r;
  reg  [17:0]       pend_int_r;
  reg  [23:0]       pend_den_r;
  reg               div_pend_r;
  reg  [1:0]        ctrl_r;
  reg  [23:0]       ph_thr_r;
  reg  [23:0]       fr_thr_r;
  reg  [31:0]       rates_r;
  reg  [FTW_W-1:0]  clamp_lo_r;
  reg  [FTW_W-1:0]  clamp_hi_r;
  reg  [3:0]        avg_sh_r;
  reg  [12:0]       ph_lvl_r;
  reg  [12:0]       fr_lvl_r;
  reg  [FTW_W+15:0] sum_r;
  reg  [15:0]       cnt_r;
  reg  [FTW_W-1:0]  avg_r;
  reg               avg_ok_r;
  reg  [31:0]       rd_nxt;

  wire [11:0]       ridx    = haddr[13:2];
  wire              take    = hsel & htrans[1] & hready;
  wire              wr_now  = wr_pend_r;
  // [R2] commit strobe
  wire              commit  = wr_now && widx_r == `IDX_UPDATE &&
                              hwdata[7:0] == `COMMIT_VAL;
  wire              hold_req = ctrl_r[`CTRL_HOLD] | ~ref_valid;
  wire              free_req = ctrl_r[`CTRL_FREE];
  wire              open_st  = state_r == ST_FREE || state_r == ST_HOLD;
  wire              div_diff = sh_int_r != fb_integer ||
                               sh_den_r != fb_denominator;
  wire              go_brief = state_r == ST_CLOSED && !free_req &&
                               !hold_req && (ref_switch | div_pend_r);
  // [R11] detectors frozen through transitions
  wire              freeze   = phase_step | bw_change | state_r == ST_BRIEF;
  wire [FTW_W-1:0]  ftw_c    = clamp(ftw_in, clamp_lo_r, clamp_hi_r);
  wire [FTW_W+15:0] sum_nxt  = sum_r + {16'h0000, ftw_c};
  wire [15:0]       cnt_end  = (16'h0001 << avg_sh_r) - 16'h0001;
  wire [FTW_W+15:0] sum_sh   = sum_nxt >> avg_sh_r;

  // ahb address phase capture and response
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      widx_r    <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= take & hwrite;
      if (take)
        widx_r <= ridx;
      if (take & ~hwrite)
        hrdata <= rd_nxt;
    end
  end

  // read decode, unmapped reads return zero
  always @* begin
    rd_nxt = 32'h00000000;
    case (ridx)
      `IDX_UPDATE:   rd_nxt = {24'h000000, update_r};
      `IDX_FB_INT:   rd_nxt = {14'h0000, sh_int_r};
      `IDX_FB_NUM:   rd_nxt = {8'h00, sh_num_r};
      `IDX_FB_DEN:   rd_nxt = {8'h00, sh_den_r};
      `IDX_CTRL:     rd_nxt = {30'h00000000, ctrl_r};
      `IDX_PH_THR:   rd_nxt = {8'h00, ph_thr_r};
      `IDX_FR_THR:   rd_nxt = {8'h00, fr_thr_r};
      `IDX_RATES:    rd_nxt = rates_r;
      `IDX_CLAMP_LO: rd_nxt = clamp_lo_r[31:0];
      `IDX_CLAMP_HI: rd_nxt = clamp_hi_r[31:0];
      `IDX_AVG:      rd_nxt = {28'h0000000, avg_sh_r};
      `IDX_STATUS:   rd_nxt = {25'h0000000, div_pend_r, avg_ok_r,
                               state_r, freq_lock, phase_lock};
      `IDX_AVG_FTW:  rd_nxt = avg_r[31:0];
      default:       rd_nxt = 32'h00000000;
    endcase
  end

  // register writes in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      update_r   <= 8'h00;
      sh_int_r   <= 18'h00000;
      sh_num_r   <= 24'h000000;
      sh_den_r   <= 24'h000000;
      ctrl_r     <= 2'b00;
      ph_thr_r   <= 24'h000000;
      fr_thr_r   <= 24'h000000;
      rates_r    <= 32'h00000000;
      clamp_lo_r <= {FTW_W{1'b0}};
      clamp_hi_r <= `CLAMP_HI_RST;
      avg_sh_r   <= `AVG_SH_RST;
    end else if (wr_now) begin
      case (widx_r)
        `IDX_UPDATE:   update_r   <= hwdata[7:0];
        `IDX_FB_INT:   sh_int_r   <= hwdata[17:0];
        `IDX_FB_NUM:   sh_num_r   <= hwdata[23:0];
        `IDX_FB_DEN:   sh_den_r   <= hwdata[23:0];
        `IDX_CTRL:     ctrl_r     <= hwdata[1:0];
        `IDX_PH_THR:   ph_thr_r   <= hwdata[23:0];
        `IDX_FR_THR:   fr_thr_r   <= hwdata[23:0];
        `IDX_RATES:    rates_r    <= hwdata;
        `IDX_CLAMP_LO: clamp_lo_r <= hwdata[FTW_W-1:0];
        `IDX_CLAMP_HI: clamp_hi_r <= hwdata[FTW_W-1:0];
        `IDX_AVG:      avg_sh_r   <= hwdata[3:0];
        default:       update_r   <= update_r;
      endcase
    end
  end

  // divider application on commit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fb_integer     <= 18'h00000;
      fb_numerator   <= 24'h000000;
      fb_denominator <= 24'h000000;
      frac_enable    <= 1'b0;
      pend_int_r     <= 18'h00000;
      pend_den_r     <= 24'h000000;
      div_pend_r     <= 1'b0;
    end else begin
      // [R19] fraction bypass
      frac_enable <= fb_numerator != 24'h000000 &&
                     fb_denominator != 24'h000000;
      // [R3] numerator goes straight in
      if (commit)
        fb_numerator <= sh_num_r;
      // [R4] integer or denominator waits for a brief holdover, applied at once in free run or holdover
      if (commit && div_diff && !open_st) begin
        pend_int_r <= sh_int_r;
        pend_den_r <= sh_den_r;
      end
      if (commit && div_diff && open_st) begin
        fb_integer     <= sh_int_r;
        fb_denominator <= sh_den_r;
      end else if (go_brief && div_pend_r) begin
        fb_integer     <= pend_int_r;
        fb_denominator <= pend_den_r;
      end
      // a new commit wins over the take of an older one
      if (commit && div_diff && !open_st)
        div_pend_r <= 1'b1;
      else if (go_brief || open_st)
        div_pend_r <= 1'b0;
    end
  end

  // loop control state machine
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= ST_HOLD;
      tmr_r      <= 8'h00;
      param_load <= 1'b0;
    end else begin
      param_load <= 1'b0;
      if (tmr_r != 8'h00)
        tmr_r <= tmr_r - 8'h01;
      case (state_r)
        ST_FREE: begin
          if (!free_req)
            state_r <= ST_HOLD;
        end
        // [R16] [R18] holdover until reference and no forced bit
        ST_HOLD: begin
          if (free_req)
            state_r <= ST_FREE;
          else if (!hold_req) begin
            // [R17] recovery reloads profile parameters
            state_r    <= ST_RECOVER;
            tmr_r      <= `RECOV_CYC;
            param_load <= 1'b1;
          end
        end
        ST_RECOVER: begin
          if (free_req)
            state_r <= ST_FREE;
          else if (hold_req)
            state_r <= ST_HOLD;
          else if (tmr_r == 8'h00)
            state_r <= ST_CLOSED;
        end
        // [R1] [R15] closed loop; switch and integer or denominator change go brief
        ST_CLOSED: begin
          if (free_req)
            state_r <= ST_FREE;
          else if (hold_req)
            state_r <= ST_HOLD;
          else if (go_brief) begin
            state_r <= ST_BRIEF;
            tmr_r   <= `BRIEF_CYC;
          end
        end
        ST_BRIEF: begin
          if (free_req)
            state_r <= ST_FREE;
          else if (hold_req)
            state_r <= ST_HOLD;
          else if (tmr_r == 8'h00) begin
            state_r    <= ST_CLOSED;
            param_load <= 1'b1;
          end
        end
        default: state_r <= ST_HOLD;
      endcase
    end
  end

  // phase and frequency lock detectors
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // [R20] start empty and unlocked
      ph_lvl_r   <= `LVL_EMPTY;
      fr_lvl_r   <= `LVL_EMPTY;
      phase_lock <= 1'b0;
      freq_lock  <= 1'b0;
    end else if (open_st) begin
      // [R10] open loop reports phase unlock
      ph_lvl_r   <= `LVL_EMPTY;
      phase_lock <= 1'b0;
    end else if (pd_valid && !freeze) begin
      // [R5] [R7] [R8] [R9] phase bucket
      ph_lvl_r <= bucket(ph_lvl_r, mag(phase_err) <= ph_thr_r,
                         rates_r[7:0], rates_r[15:8]);
      // [R12] frequency bucket on period deviation
      fr_lvl_r <= bucket(fr_lvl_r, mag(period_dev) <= fr_thr_r,
                         rates_r[23:16], rates_r[31:24]);
      // [R6] hysteresis on the stored level
      phase_lock <= lock_next(ph_lvl_r, phase_lock);
      freq_lock  <= lock_next(fr_lvl_r, freq_lock);
    end
  end

  // tuning word clamp, history average and holdover drive
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ftw_out  <= {FTW_W{1'b0}};
      sum_r    <= {(FTW_W+16){1'b0}};
      cnt_r    <= 16'h0000;
      avg_r    <= {FTW_W{1'b0}};
      avg_ok_r <= 1'b0;
    end else if (state_r == ST_CLOSED || state_r == ST_RECOVER) begin
      if (ftw_valid) begin
        // [R13] clamped word drives the oscillator
        ftw_out <= ftw_c;
        // [R14] average over 2^shift samples
        if (cnt_r >= cnt_end) begin
          avg_r    <= sum_sh[FTW_W-1:0];
          avg_ok_r <= 1'b1;
          sum_r    <= {(FTW_W+16){1'b0}};
          cnt_r    <= 16'h0000;
        end else begin
          sum_r <= sum_nxt;
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end else if (state_r == ST_HOLD && avg_ok_r) begin
      // [R14] [R16] holdover drives the history average
      ftw_out <= avg_r;
    end
  end

  // state out
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      loop_state <= ST_HOLD;
    else
      loop_state <= state_r;
  end

endmodule

/* sim/dpll_lock_monitor.sv */
module dpll_lock_monitor (
  // clock and reset
  input logic        hclk,
  input logic        hresetn,
  // bus answer
  input logic        hreadyout,
  input logic        hresp,
  // loop inputs and outputs
  input logic        pd_valid,
  input logic        phase_step,
  input logic        bw_change,
  input logic [2:0]  loop_state,
  input logic        param_load,
  input logic        phase_lock,
  input logic        freq_lock,
  input logic [23:0] fb_numerator,
  input logic [23:0] fb_denominator,
  input logic        frac_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // bus always ready with okay
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  frac_bypass_a: assert property (
    frac_enable == ($past(fb_numerator) != 0 && $past(fb_denominator) != 0))
    else $error("fraction enable wrong");
  // lock rises only on a sample
  phase_rise_a: assert property ($rose(phase_lock) |-> $past(pd_valid))
    else $error("phase lock rose without sample");
  freq_rise_a: assert property ($rose(freq_lock) |-> $past(pd_valid))
    else $error("freq lock rose without sample");
  // phase unlocked in free run or holdover
  hold_unlock_a: assert property ((loop_state <= 3'h1)[*2] |-> !phase_lock)
    else $error("phase lock shown in holdover");
  freeze_keep_a: assert property (
    (phase_step || bw_change) && $past(phase_step || bw_change)
    && loop_state == 3'h4 |-> $stable(phase_lock) && $stable(freq_lock))
    else $error("lock changed while frozen");
  // brief holdover lasts seventeen cycles, timer load plus countdown
  brief_len_a: assert property ($rose(loop_state == 3'h2) |->
    ##16 loop_state == 3'h2 ##1 loop_state != 3'h2)
    else $error("brief holdover length wrong");
  brief_load_a: assert property (
    $fell(loop_state == 3'h2) |-> param_load || $past(param_load))
    else $error("no parameter load after brief");
  // recovery lasts nine cycles, timer load plus countdown
  recov_len_a: assert property ($rose(loop_state == 3'h3) |->
    ##8 loop_state == 3'h3 ##1 loop_state != 3'h3)
    else $error("recovery length wrong");
endmodule

bind dpll_loop_control dpll_lock_monitor mon (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .pd_valid(pd_valid), .phase_step(phase_step), .bw_change(bw_change),
  .loop_state(loop_state), .param_load(param_load),
  .phase_lock(phase_lock), .freq_lock(freq_lock),
  .fb_numerator(fb_numerator), .fb_denominator(fb_denominator),
  .frac_enable(frac_enable));

/* sim/ref_sample_source.sv */
module ref_sample_source (
  // clock
  input  logic        hclk,
  // detector samples
  output logic        pd_valid,
  output logic [23:0] phase_err,
  output logic [23:0] period_dev,
  // tuning word samples
  output logic        ftw_valid,
  output logic [31:0] ftw_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle lines at time zero
  initial begin
    pd_valid = 1'b0;
    ftw_valid = 1'b0;
    phase_err = 24'h000000;
    period_dev = 24'h000000;
    ftw_in = 32'h00000000;
  end
  // one sample, then data inverted so stale values never match
  task automatic sample(input logic [23:0] pe, input logic [23:0] pd);
    @(posedge hclk);
    pd_valid <= 1'b1;
    phase_err <= pe;
    period_dev <= pd;
    @(posedge hclk);
    pd_valid <= 1'b0;
    phase_err <= ~pe;
    period_dev <= ~pd;
  endtask
  // one tuning word from the loop filter
  task automatic word(input logic [31:0] w);
    @(posedge hclk);
    ftw_valid <= 1'b1;
    ftw_in <= w;
    @(posedge hclk);
    ftw_valid <= 1'b0;
    ftw_in <= ~w;
  endtask
endmodule

/* sim/dpll_loop_control_test.sv */
`include "dpll_loop_regs.vh"
module dpll_loop_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hwrite, ref_valid, ref_switch;
  logic        phase_step, bw_change;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, rd, w, n, d;
  logic [31:0] seed = 32'h00001EE3;
  wire         hreadyout, hresp, pd_valid, ftw_valid, param_load;
  wire         phase_lock, freq_lock, frac_enable;
  wire  [2:0]  loop_state;
  wire  [17:0] fb_integer;
  wire  [23:0] phase_err, period_dev, fb_numerator, fb_denominator;
  wire  [31:0] hrdata, ftw_in, ftw_out;
  int          error_cnt, num_checks, lvl[2], lk[2];
  int          fill[2] = '{200, 255};
  int          drain[2] = '{64, 32};
  int          thr[2] = '{1000, 500};
  // design and far-side sample source
  dpll_loop_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pd_valid(pd_valid),
    .phase_err(phase_err), .period_dev(period_dev), .ref_valid(ref_valid),
    .ref_switch(ref_switch), .phase_step(phase_step), .bw_change(bw_change),
    .ftw_valid(ftw_valid), .ftw_in(ftw_in), .phase_lock(phase_lock),
    .freq_lock(freq_lock), .loop_state(loop_state), .param_load(param_load),
    .ftw_out(ftw_out), .fb_integer(fb_integer), .fb_numerator(fb_numerator),
    .fb_denominator(fb_denominator), .frac_enable(frac_enable));
  ref_sample_source p (.hclk(hclk), .pd_valid(pd_valid),
    .phase_err(phase_err), .period_dev(period_dev), .ftw_valid(ftw_valid),
    .ftw_in(ftw_in));
  // clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int step(int l, logic ok, int f, int dr);
    return ok ? (l + f > 2048 ? 2048 : l + f)
              : (l - dr < -2048 ? -2048 : l - dr);
  endfunction
  function automatic int hyst(int l, int k);
    return l < -1024 ? 0 : (l > 1024 ? 1 : k);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // single ahb-lite transfer, read data kept in rd
  task automatic bus(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wd);
    haddr <= {18'h00000, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [11:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h00000000);
    chk(rd, e);
  endtask
  task automatic wait_st(input logic [2:0] s);
    for (int i = 0; i < 300 && loop_state !== s; i++) @(posedge hclk);
    chk(loop_state, s);
  endtask
  // one sample, expected locks from the model
  task automatic smp(input int pe, input int pd);
    int e[2];
    e = '{pe, pd};
    p.sample(pe[23:0], pd[23:0]);
    if (!(phase_step || bw_change)) begin
      for (int i = 0; i < 2; i++) begin
        lk[i] = hyst(lvl[i], lk[i]);
        lvl[i] = step(lvl[i], (e[i] < 0 ? -e[i] : e[i]) <= thr[i],
                      fill[i], drain[i]);
      end
    end
    // locks settle after the sampling edge
    @(negedge hclk);
    chk(phase_lock, lk[0]);
    chk(freq_lock, lk[1]);
    @(posedge hclk);
  endtask
  task automatic hold_in(input logic [2:0] s);
    wait_st(s);
    lvl[0] = -2048;
    lk[0] = 0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    #1500000;
    error_cnt++;
    stop_test();
  end
  // main sequence
  initial begin
    {hresetn, hwrite, ref_valid, ref_switch, phase_step, bw_change} = 6'h00;
    {haddr, hwdata, htrans} = 66'h0;
    lvl = '{-2048, -2048};
    lk = '{0, 0};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(loop_state, 3'h1);
    rchk(`IDX_CLAMP_HI, `CLAMP_HI_RST);
    rchk(`IDX_AVG, {28'h0000000, `AVG_SH_RST});
    bus(1'b1, 12'h3FF, 32'hFFFFFFFF);
    rchk(12'h3FF, 32'h00000000);
    bus(1'b1, `IDX_PH_THR, 32'h000003E8);
    bus(1'b1, `IDX_FR_THR, 32'h000001F4);
    bus(1'b1, `IDX_RATES, 32'h20FF40C8);
    bus(1'b1, `IDX_AVG, 32'h00000002);
    bus(1'b1, `IDX_CLAMP_LO, 32'h00001000);
    bus(1'b1, `IDX_CLAMP_HI, 32'h00002000);
    ref_valid <= 1'b1;
    bus(1'b1, `IDX_CTRL, 32'h00000000);
    wait_st(3'h4);
    $display("test setup done");
    // random samples with edge cases and a failing burst
    for (int i = 0; i < 120; i++) begin
      if (i == 30) smp(1000, 500);
      else if (i == 31) smp(-1001, -501);
      else if (i >= 40 && i < 70) smp(3000, -3000);
      else smp(int'(rnd() % 4001) - 2000, int'(rnd() % 2001) - 1000);
    end
    $display("test detectors done");
    // freezing events ignore failing samples
    for (int k = 0; k < 2; k++) begin
      {phase_step, bw_change} <= k ? 2'h1 : 2'h2;
      @(posedge hclk);
      repeat (4) smp(3000, 3000);
      {phase_step, bw_change} <= 2'h0;
    end
    $display("test freeze done");
    // tuning word clamp and average
    for (int i = 0; i < 12; i++) begin
      w = i < 4 ? (32'h00000800 << i) : 32'h00001800;
      p.word(w);
      @(posedge hclk);
      chk(ftw_out, w < 32'h1000 ? 32'h1000 : (w > 32'h2000 ? 32'h2000 : w));
    end
    rchk(`IDX_AVG_FTW, 32'h00001800);
    $display("test clamp done");
    // divider commit
    n = (rnd() & 32'h00FFFFFF) | 32'h1;
    d = (rnd() & 32'h00FFFFFF) | 32'h1;
    w = rnd() & 32'h0003FFFF;
    bus(1'b1, `IDX_FB_NUM, n);
    chk(fb_numerator, 24'h000000);
    bus(1'b1, `IDX_UPDATE, {24'h000000, `COMMIT_VAL});
    @(posedge hclk);
    chk(fb_numerator, n);
    chk(loop_state, 3'h4);
    bus(1'b1, `IDX_FB_INT, w);
    bus(1'b1, `IDX_FB_DEN, d);
    bus(1'b1, `IDX_UPDATE, 32'h00000002);
    rchk(`IDX_UPDATE, 32'h00000002);
    chk(fb_integer, 18'h00000);
    bus(1'b1, `IDX_UPDATE, {24'h000000, `COMMIT_VAL});
    wait_st(3'h2);
    chk(fb_integer, w);
    chk(fb_denominator, d);
    wait_st(3'h4);
    chk(frac_enable, 1'b1);
    bus(1'b1, `IDX_FB_NUM, 32'h00000000);
    bus(1'b1, `IDX_UPDATE, {24'h000000, `COMMIT_VAL});
    repeat (2) @(posedge hclk);
    chk(frac_enable, 1'b0);
    $display("test divider done");
    // forced holdover holds frequency and ignores the reference
    bus(1'b1, `IDX_CTRL, 32'h00000001);
    hold_in(3'h1);
    repeat (3) @(posedge hclk);
    chk(phase_lock, 1'b0);
    chk(ftw_out, 32'h00001800);
    rchk(`IDX_STATUS, 32'h00000024 | (lk[1] << 1));
    p.word(32'h00001F00);
    repeat (40) @(posedge hclk);
    chk(ftw_out, 32'h00001800);
    chk(loop_state, 3'h1);
    bus(1'b1, `IDX_CTRL, 32'h00000000);
    wait_st(3'h3);
    wait_st(3'h4);
    ref_valid <= 1'b0;
    hold_in(3'h1);
    ref_valid <= 1'b1;
    wait_st(3'h4);
    bus(1'b1, `IDX_CTRL, 32'h00000002);
    hold_in(3'h0);
    chk(phase_lock, 1'b0);
    bus(1'b1, `IDX_CTRL, 32'h00000000);
    wait_st(3'h4);
    $display("test holdover done");
    // switchover keeps the lock indication
    repeat (20) smp(0, 0);
    ref_switch <= 1'b1;
    @(posedge hclk);
    ref_switch <= 1'b0;
    wait_st(3'h2);
    chk(phase_lock, 1'b1);
    wait_st(3'h4);
    chk(phase_lock, 1'b1);
    $display("test switchover done");
    // second reset in mid-run
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(phase_lock, 1'b0);
    chk(freq_lock, 1'b0);
    chk(loop_state, 3'h1);
    $display("test reset done");
    stop_test();
  end
endmodule
